// ### src/tzd_pkg.sv
// Package for the two-zone distance supervision block: register map,
// field layouts, reset values, setting limits and timing constants.
// Assumes one 50 MHz clock and a 32-bit plain register port.
package tzd_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLOCK_HZ = 50000000;
	localparam int unsigned TICK_TIME_MS = 10;
	localparam int unsigned TICK_CYCLES = (CLOCK_HZ / 1000) * TICK_TIME_MS;
	localparam int unsigned TICK_WIDTH = 24;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_Z1_REACH = 8'h04;
	localparam logic [7:0] ADDR_Z1_SHAPE = 8'h08;
	localparam logic [7:0] ADDR_Z1_DELAY = 8'h0c;
	localparam logic [7:0] ADDR_Z2_REACH = 8'h10;
	localparam logic [7:0] ADDR_Z2_SHAPE = 8'h14;
	localparam logic [7:0] ADDR_Z2_DELAY = 8'h18;
	localparam logic [7:0] ADDR_LOAD = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_EVENT = 8'h24;
	localparam logic [7:0] ADDR_MASK = 8'h28;

	// ==========================================================
	// Field positions
	localparam int unsigned SHAPE_OFFSET_LSB = 0;
	localparam int unsigned SHAPE_ANGLE_LSB = 8;
	localparam int unsigned SHAPE_COMP_LSB = 16;
	localparam int unsigned LOAD_PF_LSB = 0;
	localparam int unsigned LOAD_MAX_LSB = 8;
	localparam int unsigned EVENT_COUNT = 5;
	localparam int unsigned EV_Z1_INST = 0;
	localparam int unsigned EV_Z1_DELAYED = 1;
	localparam int unsigned EV_Z2_INST = 2;
	localparam int unsigned EV_Z2_DELAYED = 3;
	localparam int unsigned EV_REFUSED = 4;

	// ==========================================================
	// Scheme selector codes
	localparam logic [1:0] SCHEME_NONE = 2'h0;
	localparam logic [1:0] SCHEME_DISTANCE = 2'h1;
	localparam logic [1:0] SCHEME_VOLT_CTRL = 2'h2;
	localparam logic [1:0] SCHEME_VOLT_REST = 2'h3;

	// Compensation codes
	localparam logic [1:0] COMP_ZERO = 2'h0;
	localparam logic [1:0] COMP_MINUS30 = 2'h1;
	localparam logic [1:0] COMP_PLUS30 = 2'h2;

	// ==========================================================
	// Limits: reach in 0.1 ohm, offset in 0.1 ohm, angle in degrees,
	// delay in 10 ms, power factor in 0.01, load in 0.1 per unit
	localparam logic [9:0] REACH_OFF = 10'h000;
	localparam logic [9:0] REACH_MAX = 10'h3e8;
	localparam logic [6:0] OFFSET_MAX = 7'h64;
	localparam logic [6:0] ANGLE_MIN = 7'h2d;
	localparam logic [6:0] ANGLE_MAX = 7'h5a;
	localparam logic [15:0] DELAY_MAX = 16'h9c40;
	localparam logic [6:0] PF_OFF = 7'h00;
	localparam logic [6:0] PF_MIN = 7'h32;
	localparam logic [6:0] PF_MAX = 7'h62;
	localparam logic [4:0] LOAD_MIN = 5'h05;
	localparam logic [4:0] LOAD_MAX = 5'h1e;

	// ==========================================================
	// Reset values
	localparam logic [1:0] RESET_SCHEME = SCHEME_DISTANCE;
	localparam logic [9:0] RESET_REACH = 10'h050;
	localparam logic [6:0] RESET_OFFSET = 7'h00;
	localparam logic [6:0] RESET_ANGLE = 7'h58;
	localparam logic [1:0] RESET_COMP = COMP_ZERO;
	localparam logic [15:0] RESET_DELAY = 16'h0000;
	localparam logic [6:0] RESET_PF = 7'h50;
	localparam logic [4:0] RESET_LOAD = 5'h0c;
	localparam logic [4:0] RESET_MASK = 5'h00;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [9:0] reach;
		logic [6:0] offset;
		logic [6:0] angle;
		logic [1:0] comp;
		logic [15:0] delay;
	} tzd_zone_type;

	typedef struct packed {
		logic [6:0] min_power_factor;
		logic [4:0] max_load_per_unit;
	} tzd_load_type;

	typedef struct packed {
		logic inst_pickup;
		logic delayed_pickup;
	} tzd_pickup_type;

endpackage

// ### src/tzd_definite_timer.sv
// Definite-time delay counter for one zone, counting 10 ms ticks.
// Assumes run is the zone's combinational pickup; clears when run drops.
`timescale 1ns/10ps
module tzd_definite_timer #(
	parameter int unsigned TICK_CYCLES = tzd_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic run,
	input wire logic [15:0] delay,
	output logic expired
);
	import tzd_pkg::*;

	logic [TICK_WIDTH-1:0] sub_count;
	logic [15:0] ticks;

	// ==========================================================
	// Tick counting, restarted from zero on each new pickup
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sub_count <= '0;
			ticks <= 16'h0000;
		end else if (!run) begin
			sub_count <= '0;
			ticks <= 16'h0000;
		end else if (ticks < delay) begin
			if (sub_count == TICK_WIDTH'(TICK_CYCLES - 1)) begin
				sub_count <= '0;
				ticks <= ticks + 16'h0001;
			end else begin
				sub_count <= sub_count + 1'b1;
			end
		end
	end

	// Expiry follows run on the same edge, so a drop clears it at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			expired <= 1'b0;
		end else begin
			expired <= run && (ticks >= delay);
		end
	end

endmodule

// ### src/tzd_distance_supervision.sv
// Two-zone phase distance supervision: enables, blocking, load
// encroachment gate, instantaneous and definite-time pickup outputs,
// setting registers, event status and interrupt.
// Assumes mho comparators and the load region detector sit outside and
// deliver levels synchronous to CLOCK.
//
// Summary of operation
// - Zones run only with distance scheme selected
// - Reach OFF disables that zone completely
// - Reach 0.1-100.0, offset 0.0-10.0 ohms each
// - Torque angle settable 45 to 90 degrees
// - Compensation angle only 0, -30, +30
// - Delayed pickup after 0.00-400.00 s persistence
// - Torque control zero blocks both zones
// - Loss of potential blocks both zones
// - Power factor OFF disables load encroachment
// - Maximum load accepted 0.5 to 3.0
// - Instantaneous and delayed bit per zone
// - Load region blocks distance operation
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module tzd_distance_supervision #(
	parameter int unsigned TICK_CYCLES = tzd_pkg::TICK_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WRITE,
	input wire logic READ,
	output logic [31:0] RDATA,
	input wire logic ZONE1_MHO_PICKUP,
	input wire logic ZONE2_MHO_PICKUP,
	input wire logic LOAD_REGION,
	input wire logic DISTANCE_TORQUE_CONTROL,
	input wire logic LOSS_OF_POTENTIAL,
	output tzd_pkg::tzd_zone_type ZONE1_SETTINGS,
	output tzd_pkg::tzd_zone_type ZONE2_SETTINGS,
	output tzd_pkg::tzd_load_type LOAD_SETTINGS,
	output tzd_pkg::tzd_pickup_type ZONE1_PICKUP,
	output tzd_pkg::tzd_pickup_type ZONE2_PICKUP,
	output logic IRQ
);
	import tzd_pkg::*;

	// ==========================================================
	// Setting checks
	function automatic logic reach_ok(input logic [9:0] v);
		reach_ok = (v <= REACH_MAX);
	endfunction

	function automatic logic shape_ok(input logic [31:0] d);
		logic [6:0] off;
		logic [6:0] ang;
		logic [1:0] cmp;
		off = d[SHAPE_OFFSET_LSB +: 7];
		ang = d[SHAPE_ANGLE_LSB +: 7];
		cmp = d[SHAPE_COMP_LSB +: 2];
		shape_ok = (off <= OFFSET_MAX) && (ang >= ANGLE_MIN) && (ang <= ANGLE_MAX)
			&& ((cmp == COMP_ZERO) || (cmp == COMP_MINUS30) || (cmp == COMP_PLUS30));
	endfunction

	function automatic logic load_ok(input logic [31:0] d);
		logic [6:0] pf;
		logic [4:0] mx;
		pf = d[LOAD_PF_LSB +: 7];
		mx = d[LOAD_MAX_LSB +: 5];
		load_ok = ((pf == PF_OFF) || ((pf >= PF_MIN) && (pf <= PF_MAX)))
			&& (mx >= LOAD_MIN) && (mx <= LOAD_MAX);
	endfunction

	// Live pickup view, shared by status read and event edges
	function automatic logic [3:0] pickup_word(input logic [1:0] i, input logic [1:0] e);
		pickup_word = {e[1], i[1], e[0], i[0]};
	endfunction

	function automatic logic [31:0] zone_word(input tzd_zone_type z, input logic [1:0] sel);
		zone_word = 32'h00000000;
		case (sel)
			2'h0: zone_word[9:0] = z.reach;
			2'h1: begin
				zone_word[SHAPE_OFFSET_LSB +: 7] = z.offset;
				zone_word[SHAPE_ANGLE_LSB +: 7] = z.angle;
				zone_word[SHAPE_COMP_LSB +: 2] = z.comp;
			end
			2'h2: zone_word[15:0] = z.delay;
			default: zone_word = 32'h00000000;
		endcase
	endfunction

	// ==========================================================
	// Register storage
	logic [1:0] backup_scheme_select;
	tzd_zone_type zone [2];
	logic [6:0] min_power_factor;
	logic [4:0] max_load_per_unit;
	logic [EVENT_COUNT-1:0] event_status;
	logic [EVENT_COUNT-1:0] event_mask;

	logic write_refused;
	logic [1:0] zone_sel;
	logic [1:0] field_sel;
	logic zone_hit;

	// Decode a zone register address into zone index and field
	always_comb begin
		zone_hit = 1'b1;
		zone_sel = 2'h0;
		field_sel = 2'h0;
		case (ADDR)
			ADDR_Z1_REACH: field_sel = 2'h0;
			ADDR_Z1_SHAPE: field_sel = 2'h1;
			ADDR_Z1_DELAY: field_sel = 2'h2;
			ADDR_Z2_REACH: begin
				zone_sel = 2'h1;
				field_sel = 2'h0;
			end
			ADDR_Z2_SHAPE: begin
				zone_sel = 2'h1;
				field_sel = 2'h1;
			end
			ADDR_Z2_DELAY: begin
				zone_sel = 2'h1;
				field_sel = 2'h2;
			end
			default: zone_hit = 1'b0;
		endcase
	end

	// Out-of-range values are refused whole so a zone never runs
	// on a half-written setting
	always_comb begin
		write_refused = 1'b0;
		if (WRITE) begin
			case (ADDR)
				ADDR_Z1_REACH, ADDR_Z2_REACH: write_refused = !reach_ok(WDATA[9:0]);
				ADDR_Z1_SHAPE, ADDR_Z2_SHAPE: write_refused = !shape_ok(WDATA);
				ADDR_Z1_DELAY, ADDR_Z2_DELAY: write_refused = (WDATA[15:0] > DELAY_MAX);
				ADDR_LOAD: write_refused = !load_ok(WDATA);
				default: write_refused = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Scheme and load settings
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			backup_scheme_select <= RESET_SCHEME;
			min_power_factor <= RESET_PF;
			max_load_per_unit <= RESET_LOAD;
		end else if (WRITE && !write_refused) begin
			if (ADDR == ADDR_CONTROL) begin
				backup_scheme_select <= WDATA[1:0];
			end
			if (ADDR == ADDR_LOAD) begin
				min_power_factor <= WDATA[LOAD_PF_LSB +: 7];
				max_load_per_unit <= WDATA[LOAD_MAX_LSB +: 5];
			end
		end
	end

	// ==========================================================
	// Zone settings, each zone independent
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 2; i++) begin
				zone[i].reach <= RESET_REACH;
				zone[i].offset <= RESET_OFFSET;
				zone[i].angle <= RESET_ANGLE;
				zone[i].comp <= RESET_COMP;
				zone[i].delay <= RESET_DELAY;
			end
		end else if (WRITE && !write_refused && zone_hit) begin
			case (field_sel)
				2'h0: zone[zone_sel[0]].reach <= WDATA[9:0];
				2'h1: begin
					zone[zone_sel[0]].offset <= WDATA[SHAPE_OFFSET_LSB +: 7];
					zone[zone_sel[0]].angle <= WDATA[SHAPE_ANGLE_LSB +: 7];
					zone[zone_sel[0]].comp <= WDATA[SHAPE_COMP_LSB +: 2];
				end
				2'h2: zone[zone_sel[0]].delay <= WDATA[15:0];
				default: zone[zone_sel[0]].delay <= zone[zone_sel[0]].delay;
			endcase
		end
	end

	// ==========================================================
	// Supervision gate
	logic scheme_on;
	logic block_all;
	logic load_block;
	logic [1:0] mho;
	logic [1:0] next_inst;
	logic [1:0] inst;
	logic [1:0] expired;

	assign mho = {ZONE2_MHO_PICKUP, ZONE1_MHO_PICKUP};

	always_comb begin
		scheme_on = (backup_scheme_select == SCHEME_DISTANCE);
		load_block = (min_power_factor != PF_OFF) && LOAD_REGION;
		block_all = !DISTANCE_TORQUE_CONTROL || LOSS_OF_POTENTIAL || load_block;
		for (int i = 0; i < 2; i++) begin
			next_inst[i] = scheme_on && (zone[i].reach != REACH_OFF) && !block_all
				&& mho[i];
		end
	end

	// Pickup bits leave on flops, one edge after the inputs
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			inst <= 2'h0;
		end else begin
			inst <= next_inst;
		end
	end

	// ==========================================================
	// Definite-time delays
	// Fed from the unregistered pickup, so a zero delay
	// raises both bits on the same edge
	// persistence timer per zone
	for (genvar g = 0; g < 2; g++) begin : g_timer
		tzd_definite_timer #(
			.TICK_CYCLES(TICK_CYCLES)
		) u_timer (
			.clock(CLOCK),
			.resetn(RESETN),
			.run(next_inst[g]),
			.delay(zone[g].delay),
			.expired(expired[g])
		);
	end

	// ==========================================================
	// Outputs
	// two bits per zone
	assign ZONE1_PICKUP.inst_pickup = inst[0];
	assign ZONE1_PICKUP.delayed_pickup = expired[0];
	assign ZONE2_PICKUP.inst_pickup = inst[1];
	assign ZONE2_PICKUP.delayed_pickup = expired[1];
	assign ZONE1_SETTINGS = zone[0];
	assign ZONE2_SETTINGS = zone[1];
	assign LOAD_SETTINGS.min_power_factor = min_power_factor;
	assign LOAD_SETTINGS.max_load_per_unit = max_load_per_unit;

	// ==========================================================
	// Events and interrupt
	logic [3:0] prev_out;
	logic [3:0] pickup_now;
	logic [EVENT_COUNT-1:0] event_set;
	logic [EVENT_COUNT-1:0] event_clear;

	assign pickup_now = pickup_word(inst, expired);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			prev_out <= 4'h0;
		end else begin
			prev_out <= pickup_now;
		end
	end

	always_comb begin
		event_set = '0;
		event_set[EV_Z1_INST] = inst[0] && !prev_out[0];
		event_set[EV_Z1_DELAYED] = expired[0] && !prev_out[1];
		event_set[EV_Z2_INST] = inst[1] && !prev_out[2];
		event_set[EV_Z2_DELAYED] = expired[1] && !prev_out[3];
		event_set[EV_REFUSED] = write_refused;
		event_clear = (WRITE && ADDR == ADDR_EVENT) ? WDATA[EVENT_COUNT-1:0] : '0;
	end

	// A new event in the clearing cycle survives the clear
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			event_status <= '0;
		end else begin
			event_status <= (event_status & ~event_clear) | event_set;
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			event_mask <= RESET_MASK;
		end else if (WRITE && ADDR == ADDR_MASK) begin
			event_mask <= WDATA[EVENT_COUNT-1:0];
		end
	end

	// Level output; stays up until software clears or masks the event
	assign IRQ = |(event_status & event_mask);

	// ==========================================================
	// Read port, data one cycle after the strobe
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h00000000;
		if (zone_hit) begin
			next_rdata = zone_word(zone[zone_sel[0]], field_sel);
		end else begin
			case (ADDR)
				ADDR_CONTROL: next_rdata[1:0] = backup_scheme_select;
				ADDR_LOAD: begin
					next_rdata[LOAD_PF_LSB +: 7] = min_power_factor;
					next_rdata[LOAD_MAX_LSB +: 5] = max_load_per_unit;
				end
				ADDR_STATUS: next_rdata[3:0] = pickup_now;
				ADDR_EVENT: next_rdata[EVENT_COUNT-1:0] = event_status;
				ADDR_MASK: next_rdata[EVENT_COUNT-1:0] = event_mask;
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	// Zero outside the answer cycle, so a stale word never lingers
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 32'h00000000;
		end else if (READ) begin
			RDATA <= next_rdata;
		end else begin
			RDATA <= 32'h00000000;
		end
	end

endmodule

// ### bench/tzd_trip_logic.sv
// Partner model: torque-control equation engine and trip output logic.
// Assumes pickups arrive as flops from the supervision block.
`timescale 1ns/10ps
module tzd_trip_logic
	import tzd_pkg::*;
(
	input wire logic breaker_open,
	input wire tzd_pkg::tzd_pickup_type zone1_pickup,
	input wire tzd_pkg::tzd_pickup_type zone2_pickup,
	output logic torque_control,
	output logic trip
);
	// ==========
	// Equations
	// allow only while closed
	assign torque_control = !breaker_open;
	assign trip = zone1_pickup.delayed_pickup | zone2_pickup.delayed_pickup;
endmodule

// ### bench/tzd_distance_asserts.sv
// Port checker for the two-zone distance supervision block.
// Assumes only the top module ports; bound at the foot of this file.
`timescale 1ns/10ps
module tzd_distance_asserts
	import tzd_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic ZONE1_MHO_PICKUP,
	input wire logic ZONE2_MHO_PICKUP,
	input wire logic LOAD_REGION,
	input wire logic DISTANCE_TORQUE_CONTROL,
	input wire logic LOSS_OF_POTENTIAL,
	input wire tzd_pkg::tzd_zone_type ZONE1_SETTINGS,
	input wire tzd_pkg::tzd_zone_type ZONE2_SETTINGS,
	input wire tzd_pkg::tzd_load_type LOAD_SETTINGS,
	input wire tzd_pkg::tzd_pickup_type ZONE1_PICKUP,
	input wire tzd_pkg::tzd_pickup_type ZONE2_PICKUP,
	input wire logic IRQ
);
	logic idle1;
	logic idle2;
	assign idle1 = ZONE1_PICKUP == 2'h0;
	assign idle2 = ZONE2_PICKUP == 2'h0;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);
	// ==========
	// Blocking
	AST_LOP_BLOCKS: assert property (LOSS_OF_POTENTIAL |=> idle1 && idle2)
		else $error("Pickup during loss of potential");
	AST_TORQUE_BLOCKS: assert property (!DISTANCE_TORQUE_CONTROL |=> idle1 && idle2)
		else $error("Pickup with torque control low");
	AST_REACH_OFF: assert property (ZONE1_SETTINGS.reach == REACH_OFF |=> idle1)
		else $error("Zone 1 pickup with reach off");
	AST_LOAD_BLOCKS: assert property (LOAD_SETTINGS.min_power_factor != PF_OFF
		&& LOAD_REGION |=> idle1 && idle2) else $error("Pickup inside load region");
	AST_MHO_DROP: assert property (!ZONE2_MHO_PICKUP |=> idle2)
		else $error("Zone 2 pickup held after mho drop");
	// ==========
	// Pickup and delay
	AST_INST_CAUSE: assert property ($rose(ZONE1_PICKUP.inst_pickup) |->
		$past(ZONE1_MHO_PICKUP) && $past(DISTANCE_TORQUE_CONTROL) && !$past(LOSS_OF_POTENTIAL))
		else $error("Zone 1 pickup without cause");
	AST_DELAY_ZERO: assert property (ZONE1_PICKUP.inst_pickup
		&& ZONE1_SETTINGS.delay == 16'h0 |-> ZONE1_PICKUP.delayed_pickup)
		else $error("Zero delay not immediate");
	AST_DELAY_WAIT: assert property ($rose(ZONE2_PICKUP.inst_pickup)
		&& ZONE2_SETTINGS.delay != 16'h0 |-> !ZONE2_PICKUP.delayed_pickup [*3])
		else $error("Zone 2 delayed pickup too early");
	AST_DELAYED_NEEDS_INST: assert property (ZONE2_PICKUP.delayed_pickup |-> ZONE2_PICKUP.inst_pickup)
		else $error("Delayed pickup without pickup");
	COV_Z1_INST: cover property ($rose(ZONE1_PICKUP.inst_pickup));
	COV_Z2_DELAYED: cover property ($rose(ZONE2_PICKUP.delayed_pickup));
	COV_IRQ: cover property ($rose(IRQ));
endmodule

bind tzd_distance_supervision tzd_distance_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
	.CLOCK(CLOCK), .RESETN(RESETN), .ZONE1_MHO_PICKUP(ZONE1_MHO_PICKUP),
	.ZONE2_MHO_PICKUP(ZONE2_MHO_PICKUP), .LOAD_REGION(LOAD_REGION),
	.DISTANCE_TORQUE_CONTROL(DISTANCE_TORQUE_CONTROL), .LOSS_OF_POTENTIAL(LOSS_OF_POTENTIAL),
	.ZONE1_SETTINGS(ZONE1_SETTINGS), .ZONE2_SETTINGS(ZONE2_SETTINGS),
	.LOAD_SETTINGS(LOAD_SETTINGS), .ZONE1_PICKUP(ZONE1_PICKUP), .ZONE2_PICKUP(ZONE2_PICKUP),
	.IRQ(IRQ)
);

// ### bench/two_zone_distance_supervision_bench.sv
// Self-checking bench for the two-zone distance supervision block.
// Assumes a tick of 4 cycles and the trip logic model as partner.
`timescale 1ns/10ps
module two_zone_distance_supervision_bench;
	import tzd_pkg::*;
	logic clock = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic write = 1'h0;
	logic read = 1'h0;
	logic [31:0] rdata;
	logic mho1 = 1'h0;
	logic mho2 = 1'h0;
	logic load_region = 1'h0;
	logic lop = 1'h0;
	logic breaker_open = 1'h0;
	logic torque;
	logic trip;
	logic irq;
	tzd_pickup_type z1_pick;
	tzd_pickup_type z2_pick;
	tzd_zone_type z1_set;
	tzd_zone_type z2_set;
	tzd_load_type ld_set;
	logic [1:0] e1;
	logic [1:0] e2;
	logic [31:0] d;
	int t;
	int fail_count = 0;
	int n_tests = 0;
	// Reset values of the setting registers
	logic [31:0] shadow [0:10] = '{32'h1, 32'h50, 32'h5800, 32'h0, 32'h50, 32'h5800, 32'h0,
		32'hc50, 32'h0, 32'h0, 32'h0};
	// {accepted, address, data}
	logic [31:0] tbl [0:14] = '{32'h104003e8, 32'h004003e9, 32'h00835800, 32'h10812d64,
		32'h10825a00, 32'h00805865, 32'h00805b00, 32'h00802c00, 32'h00c09c41, 32'h10c09c40,
		32'h01c00c31, 32'h11c01e62, 32'h01c01f62, 32'h01c00432, 32'h11c00500};

	always #10 clock = ~clock;

	tzd_distance_supervision #(.TICK_CYCLES(4)) DUT (
		.CLOCK(clock), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WRITE(write), .READ(read),
		.RDATA(rdata), .ZONE1_MHO_PICKUP(mho1), .ZONE2_MHO_PICKUP(mho2), .LOAD_REGION(load_region),
		.DISTANCE_TORQUE_CONTROL(torque), .LOSS_OF_POTENTIAL(lop), .ZONE1_SETTINGS(z1_set),
		.ZONE2_SETTINGS(z2_set), .LOAD_SETTINGS(ld_set), .ZONE1_PICKUP(z1_pick),
		.ZONE2_PICKUP(z2_pick),
		.IRQ(irq)
	);
	tzd_trip_logic u_trip (
		.breaker_open(breaker_open), .zone1_pickup(z1_pick), .zone2_pickup(z2_pick),
		.torque_control(torque), .trip(trip)
	);

	// ==========
	// Tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		write <= 1'h1;
		addr <= a;
		wdata <= v;
		@(posedge clock);
		write <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		read <= 1'h1;
		addr <= a;
		@(posedge clock);
		read <= 1'h0;
		#1;
		d = rdata;
	endtask

	task automatic wait_delayed();
		t = 0;
		while (z2_pick.delayed_pickup !== 1'h1) begin
			@(posedge clock);
			#1;
			t++;
			if (t > 100) begin
				fail_count++;
				summarize();
			end
		end
	endtask

	function automatic logic [1:0] pick(input logic mho, input logic [9:0] reach);
		logic on;
		on = shadow[0][1:0] == SCHEME_DISTANCE && torque && !lop && mho && reach != REACH_OFF
			&& !(shadow[7][6:0] != PF_OFF && load_region);
		return {on, on};
	endfunction

	// ==========
	// Sequence
	initial begin
		void'($urandom(32'hc5290992));
		repeat (10) @(posedge clock);
		resetn <= 1'h1;
		for (int i = 0; i < 12; i++) begin
			rd(8'(i * 4));
			check("reset register", d, i < 11 ? shadow[i] : 32'h0);
		end
		foreach (tbl[i]) begin
			wr(ADDR_EVENT, 32'h1f);
			wr(tbl[i][27:20], {12'h0, tbl[i][19:0]});
			if (tbl[i][28]) begin
				shadow[tbl[i][27:22]] = {12'h0, tbl[i][19:0]};
			end
			rd(ADDR_EVENT);
			check("refused flag", d, tbl[i][28] ? 32'h0 : 32'h10);
			rd(tbl[i][27:20]);
			check("setting", d, shadow[tbl[i][27:22]]);
		end
		check("zone1 reach pin", z1_set.reach, shadow[1]);
		check("zone1 shape pin", {z1_set.comp, 1'h0, z1_set.angle, 1'h0, z1_set.offset}, shadow[2]);
		check("zone1 delay pin", z1_set.delay, shadow[3]);
		check("zone2 reach pin", z2_set.reach, shadow[4]);
		check("load pin", {ld_set.max_load_per_unit, 1'h0, ld_set.min_power_factor}, shadow[7]);
		wr(ADDR_Z1_DELAY, 32'h0);
		for (int blk = 0; blk < 24; blk++) begin
			shadow[0] = blk % 4;
			shadow[1] = blk[2] ? 32'h0 : 32'h64;
			shadow[7] = blk[3] ? 32'hc50 : 32'hc00;
			wr(ADDR_CONTROL, shadow[0]);
			wr(ADDR_Z1_REACH, shadow[1]);
			wr(ADDR_LOAD, shadow[7]);
			repeat (20) begin
				@(posedge clock);
				e1 = pick(mho1, shadow[1][9:0]);
				e2 = pick(mho2, shadow[4][9:0]);
				mho1 <= 1'($urandom);
				mho2 <= 1'($urandom);
				load_region <= 1'($urandom);
				lop <= ($urandom % 8) == 0;
				breaker_open <= ($urandom % 8) == 0;
				#1;
				check("zone1 pickup", z1_pick, e1);
				check("zone2 pickup", z2_pick, e2);
			end
		end
		@(posedge clock);
		{mho1, mho2, lop, breaker_open, load_region} <= 5'h0;
		wr(ADDR_CONTROL, 32'h1);
		wr(ADDR_Z1_REACH, 32'h64);
		wr(ADDR_MASK, 32'h1);
		wr(ADDR_EVENT, 32'h1f);
		mho1 <= 1'h1;
		repeat (3) @(posedge clock);
		#1;
		check("irq raised", irq, 32'h1);
		check("trip", trip, 32'h1);
		rd(ADDR_STATUS);
		check("status", d, 32'h3);
		wr(ADDR_MASK, 32'h0);
		#1;
		check("irq masked", irq, 32'h0);
		wr(ADDR_MASK, 32'h1);
		wr(ADDR_EVENT, 32'h1);
		rd(ADDR_EVENT);
		check("event after clear", d, 32'h2);
		check("irq cleared", irq, 32'h0);
		// Block mid-count must restart the delay
		wr(ADDR_Z2_DELAY, 32'h2);
		mho2 <= 1'h1;
		repeat (5) @(posedge clock);
		lop <= 1'h1;
		@(posedge clock);
		lop <= 1'h0;
		wait_delayed();
		check("delay span", 32'(t >= 9 && t <= 11), 32'h1);
		check("zone2 delay pin", z2_set.delay, 32'h2);
		summarize();
	end
endmodule
